// File: hw/pit_regs.vh
// Constants for the protected-mode interrupt transfer unit.
// Assumes a 32-bit linear memory port with one-cycle read data.
`ifndef PIT_REGS_VH
`define PIT_REGS_VH
// ----------------------------------------
// Gate table geometry
// ----------------------------------------
`define PIT_GATE_ENTRIES 256
`define PIT_GATE_SHIFT 3
// ----------------------------------------
// Gate and descriptor fields
// ----------------------------------------
`define PIT_TYPE_TASK 4'h5
`define PIT_TYPE_INT 4'hE
`define PIT_TYPE_TRAP 4'hF
`define PIT_PRIV_HI 14
`define PIT_PRIV_LO 13
`define PIT_TYPE_HI 11
`define PIT_TYPE_LO 8
`define PIT_SEL_TI 2
// ----------------------------------------
// Flags word bit positions
// ----------------------------------------
`define PIT_F_TRAP 8
`define PIT_F_IE 9
`define PIT_F_NEST 14
`define PIT_F_RESUME 16
`define PIT_F_V86 17
`define PIT_FLAGS_RESET 32'h00000002
// ----------------------------------------
// Task-state stack slots
// ----------------------------------------
`define PIT_TASK_SP0 32'h00000004
`define PIT_TASK_STRIDE 32'h00000008
`endif

// File: hw/pit_priv_check.v
// Gate privilege checks for an interrupt transfer.
// Assumes gate and code segment privilege fields are already fetched.
`timescale 1ns/10ps
module pit_priv_check (
  input wire [1:0] curLevel,
  input wire [1:0] gateLevel,
  input wire [1:0] codeLevel,
  output wire checkOk
);
  // No selector privilege here: gate picked by vector number
  wire gateOk = (curLevel <= gateLevel);
  wire codeOk = (curLevel >= codeLevel);
  assign checkOk = gateOk & codeOk;
endmodule

// File: hw/pit_flag_update.v
// Flags word rewrite on entry to a handler.
// Assumes gate kind already decoded.
`timescale 1ns/10ps
`include "pit_regs.vh"
module pit_flag_update (
  input wire [31:0] flagsIn,
  input wire isIntGate,
  output reg [31:0] flagsOut
);
  always @* begin
    flagsOut = flagsIn;
    flagsOut[`PIT_F_TRAP] = 1'b0;
    flagsOut[`PIT_F_NEST] = 1'b0;
    flagsOut[`PIT_F_RESUME] = 1'b0;
    flagsOut[`PIT_F_V86] = 1'b0;
    if (isIntGate) begin
      flagsOut[`PIT_F_IE] = 1'b0;
    end
  end
endmodule

// File: hw/pit_transfer.v
// Protected-mode interrupt entry and return sequencer.
// Assumes memory answers a read on memRd with memRdata while memRd stands.
`timescale 1ns/10ps
`include "pit_regs.vh"
module pit_transfer #(
  parameter VEC_W = 8
) (
  input wire sys_clk,
  input wire reset_n,
  input wire clkEn,
  input wire intReq,
  input wire [VEC_W-1:0] intVector,
  input wire intHasErr,
  input wire [31:0] intErrCode,
  input wire retReq,
  input wire [31:0] gateTableBase,
  input wire [31:0] globalTableBase,
  input wire [31:0] localTableBase,
  input wire [31:0] taskStateBase,
  output reg memRd,
  output reg memWr,
  output reg [31:0] memAddr,
  output reg [31:0] memWdata,
  input wire [31:0] memRdata,
  output reg [15:0] codeSel,
  output reg [31:0] instrOffset,
  output reg [31:0] handlerLinear,
  output reg [15:0] stackSel,
  output reg [31:0] stackOffset,
  output reg [31:0] flagsWord,
  output reg [1:0] curLevel,
  output reg busy,
  output reg doneP,
  output reg protFaultP,
  output reg taskSwitchP,
  output reg [15:0] taskSel
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [12:0] S_IDLE = 13'h0001;
  localparam [12:0] S_GLO = 13'h0002;
  localparam [12:0] S_GHI = 13'h0004;
  localparam [12:0] S_DLO = 13'h0008;
  localparam [12:0] S_DHI = 13'h0010;
  localparam [12:0] S_TSP = 13'h0020;
  localparam [12:0] S_TSEL = 13'h0040;
  localparam [12:0] S_PUSH = 13'h0080;
  localparam [12:0] S_RIP = 13'h0100;
  localparam [12:0] S_RCS = 13'h0200;
  localparam [12:0] S_RFL = 13'h0400;
  localparam [12:0] S_RSP = 13'h0800;
  localparam [12:0] S_RSS = 13'h1000;

  reg [12:0] state_q;
  reg [31:0] gateLo_q;
  reg [31:0] gateHi_q;
  reg [31:0] descLo_q;
  reg [15:0] newSs_q;
  reg [31:0] newSp_q;
  reg [2:0] pushIdx_q;
  reg [2:0] pushLast_q;
  reg higher_q;
  reg [1:0] newLvl_q;
  reg hasErr_q;
  reg [31:0] err_q;
  reg [31:0] retIp_q;
  reg [15:0] retCs_q;
  reg [31:0] retFl_q;
  reg [31:0] retSp_q;
  reg [31:0] sp_q;

  wire [15:0] gateSel = gateLo_q[31:16];
  wire [31:0] gateOfs = {gateHi_q[31:16], gateLo_q[15:0]};
  wire [3:0] gateType = gateHi_q[`PIT_TYPE_HI:`PIT_TYPE_LO];
  wire [1:0] gatePriv = gateHi_q[`PIT_PRIV_HI:`PIT_PRIV_LO];
  wire [1:0] codePriv = memRdata[`PIT_PRIV_HI:`PIT_PRIV_LO];
  wire [31:0] codeBase = {memRdata[31:24], memRdata[7:0], descLo_q[31:16]};
  wire [31:0] descTable = gateSel[`PIT_SEL_TI] ? localTableBase : globalTableBase;
  wire isIntGate = (gateType == `PIT_TYPE_INT);
  wire privOk;
  wire [31:0] newFlags;

  pit_priv_check u_check (
    .curLevel(curLevel),
    .gateLevel(gatePriv),
    .codeLevel(codePriv),
    .checkOk(privOk)
  );

  pit_flag_update u_flags (
    .flagsIn(flagsWord),
    .isIntGate(isIntGate),
    .flagsOut(newFlags)
  );

  // ----------------------------------------
  // Frame words, oldest push first
  // ----------------------------------------
  reg [31:0] pushWord;
  always @* begin
    pushWord = 32'h00000000;
    case (pushIdx_q)
      3'h0: pushWord = {16'h0000, stackSel};
      3'h1: pushWord = stackOffset;
      3'h2: pushWord = flagsWord;
      3'h3: pushWord = {16'h0000, codeSel};
      3'h4: pushWord = instrOffset;
      3'h5: pushWord = err_q;
      default: pushWord = 32'h00000000;
    endcase
  end

  wire [31:0] spDec = sp_q - 32'h00000004;

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q <= S_IDLE;
      gateLo_q <= 32'h00000000;
      gateHi_q <= 32'h00000000;
      descLo_q <= 32'h00000000;
      newSs_q <= 16'h0000;
      newSp_q <= 32'h00000000;
      pushIdx_q <= 3'h0;
      pushLast_q <= 3'h0;
      higher_q <= 1'b0;
      newLvl_q <= 2'h0;
      hasErr_q <= 1'b0;
      err_q <= 32'h00000000;
      retIp_q <= 32'h00000000;
      retCs_q <= 16'h0000;
      retFl_q <= 32'h00000000;
      retSp_q <= 32'h00000000;
      sp_q <= 32'h00000000;
      memRd <= 1'b0;
      memWr <= 1'b0;
      memAddr <= 32'h00000000;
      memWdata <= 32'h00000000;
      codeSel <= 16'h0000;
      instrOffset <= 32'h00000000;
      handlerLinear <= 32'h00000000;
      stackSel <= 16'h0000;
      stackOffset <= 32'h00000000;
      flagsWord <= `PIT_FLAGS_RESET;
      curLevel <= 2'h0;
      busy <= 1'b0;
      doneP <= 1'b0;
      protFaultP <= 1'b0;
      taskSwitchP <= 1'b0;
      taskSel <= 16'h0000;
    end else if (clkEn) begin
      memRd <= 1'b0;
      memWr <= 1'b0;
      doneP <= 1'b0;
      protFaultP <= 1'b0;
      taskSwitchP <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (intReq) begin
            // Vector width caps table at 256 gates
            memAddr <= gateTableBase + ({24'h000000, intVector} << `PIT_GATE_SHIFT);
            memRd <= 1'b1;
            hasErr_q <= intHasErr;
            err_q <= intErrCode;
            busy <= 1'b1;
            state_q <= S_GLO;
          end else if (retReq) begin
            // Handler must already have dropped error code
            memAddr <= stackOffset;
            memRd <= 1'b1;
            sp_q <= stackOffset + 32'h00000004;
            busy <= 1'b1;
            state_q <= S_RIP;
          end
        end
        S_GLO: begin
          gateLo_q <= memRdata;
          memAddr <= memAddr + 32'h00000004;
          memRd <= 1'b1;
          state_q <= S_GHI;
        end
        S_GHI: begin
          gateHi_q <= memRdata;
          if (memRdata[`PIT_TYPE_HI:`PIT_TYPE_LO] == `PIT_TYPE_TASK) begin
            taskSel <= gateLo_q[31:16];
            taskSwitchP <= 1'b1;
            busy <= 1'b0;
            state_q <= S_IDLE;
          end else if (memRdata[`PIT_TYPE_HI:`PIT_TYPE_LO] != `PIT_TYPE_INT &&
                       memRdata[`PIT_TYPE_HI:`PIT_TYPE_LO] != `PIT_TYPE_TRAP) begin
            protFaultP <= 1'b1;
            busy <= 1'b0;
            state_q <= S_IDLE;
          end else begin
            memAddr <= descTable + {16'h0000, gateLo_q[31:19], 3'h0};
            memRd <= 1'b1;
            state_q <= S_DLO;
          end
        end
        S_DLO: begin
          descLo_q <= memRdata;
          memAddr <= memAddr + 32'h00000004;
          memRd <= 1'b1;
          state_q <= S_DHI;
        end
        S_DHI: begin
          if (!privOk) begin
            // Abort before any push or register load
            protFaultP <= 1'b1;
            busy <= 1'b0;
            state_q <= S_IDLE;
          end else begin
            handlerLinear <= codeBase + gateOfs;
            higher_q <= (codePriv < curLevel);
            newLvl_q <= codePriv;
            if (codePriv < curLevel) begin
              // Stack slot chosen by target level
              memAddr <= taskStateBase + `PIT_TASK_SP0 + {27'h0, codePriv, 3'h0};
              memRd <= 1'b1;
              state_q <= S_TSP;
            end else begin
              sp_q <= stackOffset;
              pushIdx_q <= 3'h2;
              pushLast_q <= hasErr_q ? 3'h5 : 3'h4;
              state_q <= S_PUSH;
            end
          end
        end
        S_TSP: begin
          newSp_q <= memRdata;
          memAddr <= memAddr + 32'h00000004;
          memRd <= 1'b1;
          state_q <= S_TSEL;
        end
        S_TSEL: begin
          newSs_q <= memRdata[15:0];
          sp_q <= newSp_q;
          pushIdx_q <= 3'h0;
          pushLast_q <= hasErr_q ? 3'h5 : 3'h4;
          state_q <= S_PUSH;
        end
        S_PUSH: begin
          memAddr <= spDec;
          memWdata <= pushWord;
          memWr <= 1'b1;
          sp_q <= spDec;
          pushIdx_q <= pushIdx_q + 3'h1;
          if (pushIdx_q == pushLast_q) begin
            // Checks passed in S_DHI, so loads are safe now
            codeSel <= gateSel;
            instrOffset <= gateOfs;
            flagsWord <= newFlags;
            stackOffset <= spDec;
            if (higher_q) begin
              stackSel <= newSs_q;
              // Level moves with the rest of the handler state
              curLevel <= newLvl_q;
            end
            doneP <= 1'b1;
            busy <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        S_RIP: begin
          retIp_q <= memRdata;
          memAddr <= sp_q;
          memRd <= 1'b1;
          sp_q <= sp_q + 32'h00000004;
          state_q <= S_RCS;
        end
        S_RCS: begin
          retCs_q <= memRdata[15:0];
          memAddr <= sp_q;
          memRd <= 1'b1;
          sp_q <= sp_q + 32'h00000004;
          state_q <= S_RFL;
        end
        S_RFL: begin
          if (retCs_q[1:0] == curLevel) begin
            flagsWord <= memRdata;
            codeSel <= retCs_q;
            instrOffset <= retIp_q;
            stackOffset <= sp_q;
            doneP <= 1'b1;
            busy <= 1'b0;
            state_q <= S_IDLE;
          end else if (retCs_q[1:0] < curLevel) begin
            // Return to more privilege is illegal
            protFaultP <= 1'b1;
            busy <= 1'b0;
            state_q <= S_IDLE;
          end else begin
            retFl_q <= memRdata;
            memAddr <= sp_q;
            memRd <= 1'b1;
            sp_q <= sp_q + 32'h00000004;
            state_q <= S_RSP;
          end
        end
        S_RSP: begin
          retSp_q <= memRdata;
          memAddr <= sp_q;
          memRd <= 1'b1;
          state_q <= S_RSS;
        end
        S_RSS: begin
          flagsWord <= retFl_q;
          stackOffset <= retSp_q;
          stackSel <= memRdata[15:0];
          codeSel <= retCs_q;
          instrOffset <= retIp_q;
          curLevel <= retCs_q[1:0];
          doneP <= 1'b1;
          busy <= 1'b0;
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end
endmodule

// File: verif/pit_transfer_checker.sv
// Port assertions for the interrupt transfer unit.
// Assumes one clock with a synchronous active-low reset.
`timescale 1ns/10ps
`include "pit_regs.vh"
module pit_transfer_checker #(
  parameter VEC_W = 8
) (
  input wire sys_clk,
  input wire reset_n,
  input wire clkEn,
  input wire intReq,
  input wire [VEC_W-1:0] intVector,
  input wire retReq,
  input wire [31:0] gateTableBase,
  input wire memRd,
  input wire memWr,
  input wire [31:0] memAddr,
  input wire [15:0] codeSel,
  input wire [31:0] instrOffset,
  input wire [31:0] stackOffset,
  input wire [31:0] flagsWord,
  input wire [1:0] curLevel,
  input wire busy,
  input wire doneP,
  input wire protFaultP,
  input wire taskSwitchP
);
  // Entry or return in flight, so flag checks skip returns
  reg entry_q;
  always @(posedge sys_clk) begin
    if (!reset_n) entry_q <= 1'b0;
    else if (clkEn && !busy && intReq) entry_q <= 1'b1;
    else if (clkEn && !busy && retReq) entry_q <= 1'b0;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_gate_addr: assert property (clkEn && !busy && intReq
    |=> memRd && memAddr == gateTableBase + {$past(intVector), 3'h0})
    else $error("Gate fetch address wrong");
  a_fault_keeps: assert property (protFaultP
    |-> $stable({codeSel, instrOffset, stackOffset, flagsWord, curLevel}) [*2])
    else $error("Fault changed state");
  a_fault_nowrite: assert property (protFaultP |-> !memWr && !$past(memWr))
    else $error("Fault wrote memory");
  a_entry_flags: assert property (doneP && entry_q |-> ##[0:1]
    (!flagsWord[`PIT_F_TRAP] && !flagsWord[`PIT_F_NEST]
    && !flagsWord[`PIT_F_RESUME] && !flagsWord[`PIT_F_V86]))
    else $error("Entry left flags set");
  a_sel_load: assert property ($changed(codeSel) |-> doneP || $past(doneP))
    else $error("Selector changed early");
  a_level_load: assert property ($changed(curLevel) |-> doneP || $past(doneP))
    else $error("Level changed early");
  // Frozen cycles repeat a write, so only advancing cycles step down
  a_push_order: assert property (memWr && $past(memWr) && $past(clkEn)
    |-> memAddr == $past(memAddr) - 32'h00000004)
    else $error("Pushes not descending");
  a_task_keep: assert property (taskSwitchP
    |-> !memWr && $stable({codeSel, instrOffset, stackOffset}))
    else $error("Task gate touched handler state");
  c_entry: cover property (doneP && entry_q);
  c_fault: cover property (protFaultP);
  c_task: cover property (taskSwitchP);
endmodule
bind pit_transfer pit_transfer_checker #(.VEC_W(VEC_W)) u_chk (.sys_clk(sys_clk),
  .reset_n(reset_n), .clkEn(clkEn), .intReq(intReq), .intVector(intVector),
  .retReq(retReq), .gateTableBase(gateTableBase), .memRd(memRd), .memWr(memWr),
  .memAddr(memAddr), .codeSel(codeSel), .instrOffset(instrOffset),
  .stackOffset(stackOffset), .flagsWord(flagsWord), .curLevel(curLevel), .busy(busy),
  .doneP(doneP), .protFaultP(protFaultP), .taskSwitchP(taskSwitchP));

// File: verif/pit_mem_model.sv
// Memory holding gate, descriptor and task-state tables and stacks.
// Assumes word-aligned accesses inside an 8 KiB window.
// Read data stand in the cycle in which the read strobe stands.
`timescale 1ns/10ps
module pit_mem_model (
  input wire sys_clk,
  input wire memRd,
  input wire memWr,
  input wire [31:0] memAddr,
  input wire [31:0] memWdata,
  output wire [31:0] memRdata
);
  logic [31:0] mem [0:2047];
  always @(posedge sys_clk) begin
    if (memWr) mem[memAddr[12:2]] <= memWdata;
  end
  // Inverted outside a read so a mistimed sample never matches
  assign memRdata = memRd ? mem[memAddr[12:2]] : ~mem[memAddr[12:2]];
endmodule

// File: verif/pit_transfer_tb.sv
// Bench comparing the transfer unit with a bench model of its state.
// Assumes the memory model answers a read only while the strobe stands.
`timescale 1ns/10ps
`include "pit_regs.vh"
module pit_transfer_tb;
  localparam logic [31:0] GLOB_BASE = 32'h00000800;
  localparam logic [31:0] LOC_BASE = 32'h00000900;
  localparam logic [31:0] TASK_BASE = 32'h00000A00;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clkEn = 1'b1;
  logic intReq = 1'b0;
  logic intHasErr = 1'b0;
  logic retReq = 1'b0;
  logic [7:0] intVector = 8'h00;
  logic [31:0] intErrCode = 32'h00000000;
  wire memRd, memWr, busy, doneP, protFaultP, taskSwitchP;
  wire [31:0] memAddr, memWdata, memRdata, instrOffset, handlerLinear, stackOffset, flagsWord;
  wire [15:0] codeSel, stackSel, taskSel;
  wire [1:0] curLevel;
  int errorCnt = 0;
  int comparisons = 0;
  logic [31:0] mCs = 32'h0, mIp = 32'h0, mFl = 32'h2, mSs = 32'h0, mSp = 32'h0;
  logic [1:0] mLvl = 2'h0;
  pit_transfer #(.VEC_W(8)) DUT (.sys_clk(sys_clk), .reset_n(reset_n), .clkEn(clkEn),
    .intReq(intReq), .intVector(intVector), .intHasErr(intHasErr), .intErrCode(intErrCode),
    .retReq(retReq), .gateTableBase(32'h00001000), .globalTableBase(GLOB_BASE),
    .localTableBase(LOC_BASE), .taskStateBase(TASK_BASE), .memRd(memRd), .memWr(memWr),
    .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata), .codeSel(codeSel),
    .instrOffset(instrOffset), .handlerLinear(handlerLinear), .stackSel(stackSel),
    .stackOffset(stackOffset), .flagsWord(flagsWord), .curLevel(curLevel), .busy(busy),
    .doneP(doneP), .protFaultP(protFaultP), .taskSwitchP(taskSwitchP), .taskSel(taskSel));
  pit_mem_model MEM (.sys_clk(sys_clk), .memRd(memRd), .memWr(memWr), .memAddr(memAddr),
    .memWdata(memWdata), .memRdata(memRdata));
  initial forever #2 sys_clk = ~sys_clk;
  function automatic logic [31:0] rdm(input logic [31:0] a);
    return MEM.mem[a[12:2]];
  endfunction
  task automatic wrm(input logic [31:0] a, input logic [31:0] d);
    MEM.mem[a[12:2]] = d;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errorCnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmpState();
    chk("codeSel", mCs & 32'h0000FFFF, {16'h0, codeSel});
    chk("instrOffset", mIp, instrOffset);
    chk("flagsWord", mFl, flagsWord);
    chk("stackSel", mSs & 32'h0000FFFF, {16'h0, stackSel});
    chk("stackOffset", mSp, stackOffset);
    chk("curLevel", {30'h0, mLvl}, {30'h0, curLevel});
  endtask
  // ------------------------------------------------------------
  // Request issue; outcome 1 done, 2 fault, 3 task switch
  // ------------------------------------------------------------
  task automatic run(input bit isRet, output logic [1:0] kind);
    @(posedge sys_clk);
    if (isRet) retReq <= 1'b1;
    else intReq <= 1'b1;
    @(posedge sys_clk);
    intReq <= 1'b0;
    retReq <= 1'b0;
    #1;
    chk("busyTaken", 32'h1, {31'h0, busy});
    kind = 2'd0;
    for (int i = 0; i < 60 && kind == 2'd0; i++) begin
      @(posedge sys_clk);
      #1;
      kind = {protFaultP | taskSwitchP, doneP | taskSwitchP};
      // Freeze a running transfer for two edges; nothing may move meanwhile
      if (i == 2 && kind == 2'd0) clkEn <= 1'b0;
      if (i == 4) clkEn <= 1'b1;
    end
    chk("busyDone", 32'h0, {31'h0, busy});
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic entry(input logic [15:0] sel, input logic [3:0] typ, input logic [1:0] gPriv,
      input logic [1:0] cPriv, input bit err);
    logic [31:0] ofs, base, sp, eCode, gAddr, dAddr;
    logic [31:0] push[$];
    logic [7:0] vec;
    logic [1:0] kind, expK;
    ofs = $urandom;
    base = $urandom;
    eCode = $urandom;
    vec = 8'($urandom);
    gAddr = 32'h00001000 + {vec, 3'h0};
    dAddr = (sel[`PIT_SEL_TI] ? LOC_BASE : GLOB_BASE) + {sel[15:3], 3'h0};
    wrm(gAddr, {sel, ofs[15:0]});
    wrm(gAddr + 4, {ofs[31:16], 1'b1, gPriv, 1'b0, typ, 8'h00});
    wrm(dAddr, {base[15:0], 16'hFFFF});
    wrm(dAddr + 4, {base[31:24], 8'h40, 1'b1, cPriv, 5'h1A, base[23:16]});
    intVector <= vec;
    intHasErr <= err;
    intErrCode <= eCode;
    if (typ == `PIT_TYPE_TASK) expK = 2'd3;
    else if (typ != `PIT_TYPE_INT && typ != `PIT_TYPE_TRAP) expK = 2'd2;
    else if (mLvl <= gPriv && mLvl >= cPriv) expK = 2'd1;
    else expK = 2'd2;
    run(1'b0, kind);
    chk("entryKind", {30'h0, expK}, {30'h0, kind});
    if (expK == 2'd3) chk("taskSel", {16'h0, sel}, {16'h0, taskSel});
    if (expK == 2'd1) begin
      sp = (cPriv < mLvl) ? rdm(TASK_BASE + 4 + 8 * cPriv) : mSp;
      if (cPriv < mLvl) push = '{mSs, mSp};
      push = {push, mFl, mCs, mIp};
      if (err) push.push_back(eCode);
      foreach (push[i]) chk("push", push[i], rdm(sp - 4 * (i + 1)));
      if (cPriv < mLvl) mSs = rdm(TASK_BASE + 8 + 8 * cPriv);
      mSp = sp - 4 * push.size();
      // Trap, nested, resume and v86 bits cleared
      mFl = mFl & ~32'h00034100;
      if (typ == `PIT_TYPE_INT) mFl[`PIT_F_IE] = 1'b0;
      mCs = {16'h0, sel};
      mIp = ofs;
      mLvl = cPriv;
      chk("handlerLinear", base + ofs, handlerLinear);
    end
    cmpState();
  endtask
  task automatic retFrame();
    logic [31:0] rIp, cs, fl;
    logic [1:0] kind, expK;
    rIp = rdm(mSp);
    cs = rdm(mSp + 4);
    fl = rdm(mSp + 8);
    expK = (cs[1:0] < mLvl) ? 2'd2 : 2'd1;
    run(1'b1, kind);
    chk("returnKind", {30'h0, expK}, {30'h0, kind});
    if (expK == 2'd1) begin
      if (cs[1:0] > mLvl) begin
        mSs = rdm(mSp + 16);
        mSp = rdm(mSp + 12);
      end else begin
        mSp = mSp + 12;
      end
      mCs = cs;
      mIp = rIp;
      mFl = fl;
      mLvl = cs[1:0];
    end
    cmpState();
  endtask
  initial begin
    void'($urandom(32'h4417));
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    cmpState();
    wrm(32'h00000000, $urandom);
    wrm(32'h00000004, 32'h0000001B);
    wrm(32'h00000008, 32'h00034302);
    wrm(32'h0000000C, 32'h00000F00);
    wrm(32'h00000010, 32'h0000002B);
    wrm(TASK_BASE + 4, 32'h00000E00);
    wrm(TASK_BASE + 8, 32'h00000010);
    wrm(32'h00000F04, 32'h00000008);
    retFrame(); // drop to level 3
    retFrame(); // return to more privilege refused
    entry(16'h0008, `PIT_TYPE_INT, 2'd0, 2'd0, 1'b0); // gate too privileged
    entry(16'h000B, `PIT_TYPE_TRAP, 2'd3, 2'd0, 1'b0);
    retFrame(); // no error code on the stack
    entry(16'h000C, `PIT_TYPE_INT, 2'd3, 2'd0, 1'b1);
    entry(16'h0008, `PIT_TYPE_TRAP, 2'd3, 2'd0, 1'b1); // same level
    entry(16'h0008, `PIT_TYPE_INT, 2'd3, 2'd3, 1'b0); // weaker handler
    for (int t = 0; t < 16; t += 6) entry(16'h0008, 4'(t), 2'd3, 2'd0, 1'b0);
    entry(16'h0030, `PIT_TYPE_TASK, 2'd3, 2'd0, 1'b0);
    conclude();
  end
  initial begin
    #20000;
    errorCnt++;
    conclude();
  end
endmodule
